/* File: core/dma_channel_control.sv */
// Behaviour
// - bit 23 picks overrun 0 or 1, ch0-1
// - half-end flag set after half-count read; irq
// - half-end interrupt exists on channels 0-3 only
// - end irq when transfer-end set, enable on
// - transfer-end set at count zero, not on abort
// - handshake device pairs only with external memory or mapped device
`timescale 1ns/1ns
module dma_channel_control #(
   parameter int CHANNEL     = 0,
   parameter int COUNT_WIDTH = 24
) (
   input  wire logic                                 sys_clk,
   input  wire logic                                 rst,
   input  wire dma_channel_control_pkg::reg_req_s    reg_req,
   output logic [31:0]                               reg_rdata,
   input  wire logic                                 global_dma_enable,
   input  wire logic                                 transfer_request_pin,
   output logic                                      transfer_acknowledge_pin,
   output logic                                      bus_request,
   input  wire logic                                 bus_grant,
   output logic                                      read_strobe,
   input  wire logic                                 read_done,
   output logic                                      write_strobe,
   input  wire logic                                 write_done,
   output logic                                      transfer_done_irq,
   output logic                                      half_end_irq
);
   typedef enum logic [2:0] {IDLE, ARB, READ, WRITE, GAP} state_e;

   localparam logic [COUNT_WIDTH-1:0] ZERO_COUNT = '0;

   state_e                   state_q, state_d;
   logic [31:0]              ctrl_q, ctrl_d;
   logic [COUNT_WIDTH-1:0]   count_q, count_d;
   logic [COUNT_WIDTH-1:0]   start_q, start_d;
   logic [8:0]               gap_q, gap_d;
   logic                     skip_q, skip_d;
   logic                     te_seen_q, te_seen_d;
   logic [31:0]              rdata_q, rdata_d;
   logic                     ack_q, ack_d;
   logic                     breq_q, breq_d;
   logic                     rstb_q, rstb_d;
   logic                     wstb_q, wstb_d;
   logic                     dirq_q, dirq_d;
   logic                     hirq_q, hirq_d;

   logic [2:0] src_kind;
   logic [2:0] dst_kind;
   logic       pair_ok;
   logic       handshake;
   logic       enabled;
   logic       can_start;
   logic       ctrl_wr;

   // handshake end may only meet external memory or mapped device
   function automatic logic plain_external(input logic [2:0] k);
      return k == dma_channel_control_pkg::KIND_EXT_MEMORY ||
             k == dma_channel_control_pkg::KIND_MAPPED_DEVICE;
   endfunction : plain_external

   // decode of the programmed route and start conditions
   always_comb begin
      src_kind  = ctrl_q[dma_channel_control_pkg::SRC_KIND_LSB +: 3];
      dst_kind  = ctrl_q[dma_channel_control_pkg::DST_KIND_LSB +: 3];
      handshake = src_kind == dma_channel_control_pkg::KIND_HANDSHAKE_DEVICE ||
                  dst_kind == dma_channel_control_pkg::KIND_HANDSHAKE_DEVICE;
      pair_ok   = (src_kind != dma_channel_control_pkg::KIND_HANDSHAKE_DEVICE ||
                   plain_external(dst_kind)) &&
                  (dst_kind != dma_channel_control_pkg::KIND_HANDSHAKE_DEVICE ||
                   plain_external(src_kind));
      enabled   = ctrl_q[dma_channel_control_pkg::CHANNEL_ENABLE_BIT] && global_dma_enable;
      can_start = enabled && pair_ok && count_q != ZERO_COUNT &&
                  !ctrl_q[dma_channel_control_pkg::TRANSFER_END_BIT];
      ctrl_wr   = reg_req.wr && reg_req.addr == dma_channel_control_pkg::CTRL_OFFSET;
   end

   // register port, transfer sequencing and flag updates
   always_comb begin
      state_d   = state_q;
      ctrl_d    = ctrl_q;
      count_d   = count_q;
      start_d   = start_q;
      gap_d     = gap_q;
      skip_d    = skip_q;
      te_seen_d = te_seen_q;
      rdata_d   = 32'h0000_0000;
      rstb_d    = 1'b0;
      wstb_d    = 1'b0;
      // software writes first so that hardware sets below win
      if (ctrl_wr) begin
         ctrl_d = reg_req.wdata;
         // flags only clear by zero, pair error not at all, and transfer-end only after a read of one
         ctrl_d[dma_channel_control_pkg::TRANSFER_END_BIT] =
            ctrl_q[dma_channel_control_pkg::TRANSFER_END_BIT] &&
            !(te_seen_q && !reg_req.wdata[dma_channel_control_pkg::TRANSFER_END_BIT]);
         ctrl_d[dma_channel_control_pkg::HALF_END_FLAG_BIT] =
            ctrl_q[dma_channel_control_pkg::HALF_END_FLAG_BIT] &&
            reg_req.wdata[dma_channel_control_pkg::HALF_END_FLAG_BIT];
         ctrl_d[dma_channel_control_pkg::PAIR_ERROR_BIT] =
            ctrl_q[dma_channel_control_pkg::PAIR_ERROR_BIT];
         if (!ctrl_d[dma_channel_control_pkg::TRANSFER_END_BIT]) begin
            te_seen_d = 1'b0;
         end
      end
      if (reg_req.wr && reg_req.addr == dma_channel_control_pkg::COUNT_OFFSET) begin
         count_d = reg_req.wdata[COUNT_WIDTH-1:0];
         start_d = reg_req.wdata[COUNT_WIDTH-1:0];
      end
      if (reg_req.rd) begin
         case (reg_req.addr)
            dma_channel_control_pkg::CTRL_OFFSET: begin
               rdata_d = ctrl_q;
               if (ctrl_q[dma_channel_control_pkg::TRANSFER_END_BIT]) begin
                  te_seen_d = 1'b1;
               end
            end
            dma_channel_control_pkg::COUNT_OFFSET: rdata_d = 32'(count_q);
            dma_channel_control_pkg::START_OFFSET: rdata_d = 32'(start_q);
            default: rdata_d = 32'h0000_0000;
         endcase
      end
      // a refused route is reported rather than silently idled
      if (enabled && !pair_ok) begin
         ctrl_d[dma_channel_control_pkg::PAIR_ERROR_BIT] = 1'b1;
      end
      case (state_q)
         IDLE: begin
            if (skip_q) begin
               skip_d = 1'b0;
            end else if (can_start && transfer_request_pin) begin
               state_d = ARB;
            end
         end
         ARB: begin
            // a route made illegal while waiting for the bus never strobes
            if (!enabled || !pair_ok) begin
               state_d = IDLE;
            end else if (bus_grant) begin
               state_d = READ;
               rstb_d  = 1'b1;
            end
         end
         READ: begin
            if (read_done) begin
               count_d = count_q - 1'b1;
               // half point judged against the starting count
               if (count_d == (start_q >> 1) && start_q > 1) begin
                  ctrl_d[dma_channel_control_pkg::HALF_END_FLAG_BIT] = 1'b1;
               end
               state_d = WRITE;
               wstb_d  = 1'b1;
            end
         end
         WRITE: begin
            if (write_done) begin
               // abort shows as enable low; no end flag then
               if (count_q == ZERO_COUNT && enabled) begin
                  ctrl_d[dma_channel_control_pkg::TRANSFER_END_BIT] = 1'b1;
               end
               skip_d = ctrl_q[dma_channel_control_pkg::OVERRUN_SEL_BIT] &&
                        CHANNEL < dma_channel_control_pkg::OVERRUN_CHANNELS;
               case (ctrl_q[dma_channel_control_pkg::GAP_MODE_LSB +: 2])
                  dma_channel_control_pkg::GAP_MODE_16:  gap_d = dma_channel_control_pkg::GAP_16;
                  dma_channel_control_pkg::GAP_MODE_64:  gap_d = dma_channel_control_pkg::GAP_64;
                  dma_channel_control_pkg::GAP_MODE_256: gap_d = dma_channel_control_pkg::GAP_256;
                  default: gap_d = 9'h000;
               endcase
               // overrun 1 goes back to idle so the request level is resampled late
               state_d = (!enabled || count_q == ZERO_COUNT) ? IDLE :
                         (gap_d != 9'h000) ? GAP :
                         skip_d ? IDLE : ARB;
            end
         end
         GAP: begin
            // bus stays released for the whole gap
            gap_d = gap_q - 1'b1;
            if (!enabled) begin
               state_d = IDLE;
            end else if (gap_q == 9'h001) begin
               state_d = IDLE;
            end
         end
         default: state_d = IDLE;
      endcase
      breq_d = state_d == ARB || state_d == READ || state_d == WRITE;
      ack_d  = handshake && (state_d == READ || state_d == WRITE);
      dirq_d = ctrl_d[dma_channel_control_pkg::END_IRQ_ENABLE_BIT] &&
               ctrl_d[dma_channel_control_pkg::TRANSFER_END_BIT];
      hirq_d = CHANNEL < dma_channel_control_pkg::HALF_END_CHANNELS &&
               ctrl_d[dma_channel_control_pkg::HALF_END_IRQ_BIT] &&
               ctrl_d[dma_channel_control_pkg::HALF_END_FLAG_BIT];
   end

   // state registers only
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q   <= IDLE;
         ctrl_q    <= dma_channel_control_pkg::CTRL_RESET;
         count_q   <= '0;
         start_q   <= '0;
         gap_q     <= 9'h000;
         skip_q    <= 1'b0;
         te_seen_q <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         ack_q     <= 1'b0;
         breq_q    <= 1'b0;
         rstb_q    <= 1'b0;
         wstb_q    <= 1'b0;
         dirq_q    <= 1'b0;
         hirq_q    <= 1'b0;
      end else begin
         state_q   <= state_d;
         ctrl_q    <= ctrl_d;
         count_q   <= count_d;
         start_q   <= start_d;
         gap_q     <= gap_d;
         skip_q    <= skip_d;
         te_seen_q <= te_seen_d;
         rdata_q   <= rdata_d;
         ack_q     <= ack_d;
         breq_q    <= breq_d;
         rstb_q    <= rstb_d;
         wstb_q    <= wstb_d;
         dirq_q    <= dirq_d;
         hirq_q    <= hirq_d;
      end
   end

   assign reg_rdata                = rdata_q;
   assign transfer_acknowledge_pin = ack_q;
   assign bus_request              = breq_q;
   assign read_strobe              = rstb_q;
   assign write_strobe             = wstb_q;
   assign transfer_done_irq        = dirq_q;
   assign half_end_irq             = hirq_q;

   // checks next to the logic they guard
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   end_irq_follows_a: assert property (
      dirq_q |-> ctrl_q[dma_channel_control_pkg::TRANSFER_END_BIT])
      else $error("end irq without transfer end");
   te_needs_zero_a: assert property (
      $rose(ctrl_q[dma_channel_control_pkg::TRANSFER_END_BIT])
      |-> count_q == ZERO_COUNT && $past(state_q) == WRITE)
      else $error("transfer end set before count zero");
   te_clear_read_a: assert property (
      $fell(ctrl_q[dma_channel_control_pkg::TRANSFER_END_BIT])
      |-> $past(te_seen_q) && $past(ctrl_wr))
      else $error("transfer end cleared without read");
   te_blocks_start_a: assert property (
      ctrl_q[dma_channel_control_pkg::TRANSFER_END_BIT] && state_q == IDLE
      |=> state_q != ARB)
      else $error("start while transfer end set");
   pair_refused_a: assert property (!pair_ok |-> ##1 !read_strobe)
      else $error("illegal route transferred");
   gap_release_a: assert property (
      state_q == GAP && gap_q > 9'h002 |=> !bus_request [*2])
      else $error("bus taken during gap");
   half_irq_gate_a: assert property (
      hirq_q |-> CHANNEL < dma_channel_control_pkg::HALF_END_CHANNELS
      && ctrl_q[dma_channel_control_pkg::HALF_END_FLAG_BIT])
      else $error("half irq on wrong channel");
   half_set_read_a: assert property (
      $rose(ctrl_q[dma_channel_control_pkg::HALF_END_FLAG_BIT])
      |-> $past(state_q) == READ && $past(read_done))
      else $error("half flag outside read end");
   overrun_skip_a: assert property (skip_q && state_q == IDLE |=> state_q == IDLE)
      else $error("overrun 1 start too early");

   unit_done_c: cover property (state_q == WRITE && write_done);
   final_end_c: cover property ($rose(dirq_q));
   half_end_c:  cover property ($rose(hirq_q));
   gap_wait_c:  cover property (state_q == GAP && gap_q == 9'h001);
endmodule : dma_channel_control

/* File: core/dma_channel_control_pkg.sv */
package dma_channel_control_pkg;
   // register map, byte offsets on the plain register port
   localparam logic [7:0] CTRL_OFFSET  = 8'h00;
   localparam logic [7:0] COUNT_OFFSET = 8'h04;
   localparam logic [7:0] START_OFFSET = 8'h08;

   // control register field positions
   localparam int CHANNEL_ENABLE_BIT  = 0;
   localparam int TRANSFER_END_BIT    = 1;
   localparam int END_IRQ_ENABLE_BIT  = 2;
   localparam int GAP_MODE_LSB        = 4;
   localparam int DST_KIND_LSB        = 8;
   localparam int SRC_KIND_LSB        = 12;
   localparam int HALF_END_FLAG_BIT   = 17;
   localparam int HALF_END_IRQ_BIT    = 18;
   localparam int PAIR_ERROR_BIT      = 20;
   localparam int OVERRUN_SEL_BIT     = 23;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // channels on which the optional controls exist
   localparam int OVERRUN_CHANNELS  = 2;
   localparam int HALF_END_CHANNELS = 4;

   // intermittent release gaps in bus clocks
   localparam logic [8:0] GAP_16  = 9'h010;
   localparam logic [8:0] GAP_64  = 9'h040;
   localparam logic [8:0] GAP_256 = 9'h100;

   typedef enum logic [2:0] {
      KIND_EXT_MEMORY,
      KIND_MAPPED_DEVICE,
      KIND_HANDSHAKE_DEVICE,
      KIND_PERIPHERAL,
      KIND_INTERNAL_MEMORY
   } endpoint_kind_e;

   typedef enum logic [1:0] {
      GAP_NONE,
      GAP_MODE_16,
      GAP_MODE_64,
      GAP_MODE_256
   } gap_mode_e;

   // one register port access
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_s;
endpackage : dma_channel_control_pkg

/* File: test/dma_channel_control_bench.sv */
`timescale 1ns/1ns
module dma_channel_control_bench;
   logic                              sys_clk = 1'b0;
   logic                              rst = 1'b1;
   dma_channel_control_pkg::reg_req_s reg_req = '0;
   logic [31:0]                       reg_rdata;
   logic                              global_dma_enable = 1'b1;
   logic                              transfer_request_pin = 1'b0;
   logic                              slow = 1'b0;
   logic                              bus_request, bus_grant, read_strobe, read_done;
   logic                              write_strobe, write_done, transfer_acknowledge_pin;
   logic                              transfer_done_irq, half_end_irq;
   int                                fail_count = 0;
   int                                n_tests = 0;

   always #2 sys_clk = ~sys_clk;

   dma_channel_control dut (.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .global_dma_enable(global_dma_enable),
      .transfer_request_pin(transfer_request_pin),
      .transfer_acknowledge_pin(transfer_acknowledge_pin), .bus_request(bus_request),
      .bus_grant(bus_grant), .read_strobe(read_strobe), .read_done(read_done),
      .write_strobe(write_strobe), .write_done(write_done),
      .transfer_done_irq(transfer_done_irq), .half_end_irq(half_end_irq));

   dma_far_side_model far_side (.sys_clk(sys_clk), .rst(rst), .slow(slow),
      .bus_request(bus_request), .read_strobe(read_strobe), .write_strobe(write_strobe),
      .bus_grant(bus_grant), .read_done(read_done), .write_done(write_done));

   task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask : check

   task reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_req.addr <= a;
      reg_req.wdata <= d;
      reg_req.wr <= 1'b1;
      @(posedge sys_clk);
      reg_req.wr <= 1'b0;
   endtask : reg_write

   // data stands only in the cycle after the strobe; sampled mid-cycle
   task reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_req.addr <= a;
      reg_req.rd <= 1'b1;
      @(posedge sys_clk);
      reg_req.rd <= 1'b0;
      @(negedge sys_clk);
      d = reg_rdata;
      @(posedge sys_clk);
   endtask : reg_read

   // bounded wait on the bus request level, sampled mid-cycle; returns on an edge
   task wait_bus(input logic lvl, output int n);
      n = 0;
      @(negedge sys_clk);
      while (bus_request !== lvl && n < 600) begin
         @(negedge sys_clk);
         n++;
      end
      check(32'(bus_request), 32'(lvl), "bus level wait");
      @(posedge sys_clk);
   endtask : wait_bus

   task do_reset;
      rst <= 1'b1;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
   endtask : do_reset

   task test_full_transfer;
      logic [31:0] d;
      reg_read(8'h0c, d);
      check(d, 32'h0000_0000, "unmapped read");
      reg_read(dma_channel_control_pkg::CTRL_OFFSET, d);
      check(d, dma_channel_control_pkg::CTRL_RESET, "control reset");
      reg_write(dma_channel_control_pkg::COUNT_OFFSET, 32'h0000_0002);
      reg_write(dma_channel_control_pkg::CTRL_OFFSET, 32'h0004_0005);
      transfer_request_pin <= 1'b1;
      for (int i = 0; i < 100 && half_end_irq !== 1'b1; i++) @(negedge sys_clk);
      check(32'(half_end_irq), 32'h0000_0001, "half irq");
      check(32'(transfer_done_irq), 32'h0000_0000, "early end irq");
      for (int i = 0; i < 100 && transfer_done_irq !== 1'b1; i++) @(negedge sys_clk);
      check(32'(transfer_done_irq), 32'h0000_0001, "end irq");
      reg_read(dma_channel_control_pkg::CTRL_OFFSET, d);
      check(d & 32'h0002_0006, 32'h0002_0006, "end and half flags");
      reg_read(dma_channel_control_pkg::COUNT_OFFSET, d);
      check(d, 32'h0000_0000, "count at end");
      reg_read(dma_channel_control_pkg::START_OFFSET, d);
      check(d, 32'h0000_0002, "start count kept");
      $display("test full_transfer done");
   endtask : test_full_transfer

   // a set end flag holds off work until software clears it
   task test_end_flag_block;
      logic busy;
      int   n;
      busy = 1'b0;
      reg_write(dma_channel_control_pkg::COUNT_OFFSET, 32'h0000_0001);
      repeat (30) @(negedge sys_clk) busy |= bus_request;
      check(32'(busy), 32'h0000_0000, "start while flag set");
      reg_write(dma_channel_control_pkg::CTRL_OFFSET, 32'h0000_0001);
      wait_bus(1'b1, n);
      check(32'(bus_request), 32'h0000_0001, "start after clear");
      wait_bus(1'b0, n);
      repeat (3) @(negedge sys_clk);
      check(32'(transfer_done_irq), 32'h0000_0000, "irq while disabled");
      $display("test end_flag_block done");
   endtask : test_end_flag_block

   task test_bad_pairing;
      logic [31:0] d;
      logic        busy;
      busy = 1'b0;
      reg_read(dma_channel_control_pkg::CTRL_OFFSET, d);
      reg_write(dma_channel_control_pkg::COUNT_OFFSET, 32'h0000_0001);
      reg_write(dma_channel_control_pkg::CTRL_OFFSET, 32'h0000_2301);
      repeat (30) @(negedge sys_clk) busy |= bus_request;
      check(32'(busy), 32'h0000_0000, "illegal route started");
      reg_read(dma_channel_control_pkg::CTRL_OFFSET, d);
      check(d & 32'h0010_0002, 32'h0010_0000, "pairing error flag");
      $display("test bad_pairing done");
   endtask : test_bad_pairing

   // abort in mid unit with a slow memory: the end flag must stay clear
   task test_abort;
      logic [31:0] d;
      int          n;
      slow <= 1'b1;
      reg_write(dma_channel_control_pkg::COUNT_OFFSET, 32'h0000_0004);
      reg_write(dma_channel_control_pkg::CTRL_OFFSET, 32'h0000_0005);
      wait_bus(1'b1, n);
      repeat (2) @(posedge sys_clk);
      reg_write(dma_channel_control_pkg::CTRL_OFFSET, 32'h0000_0004);
      repeat (60) @(negedge sys_clk);
      check(32'(transfer_done_irq), 32'h0000_0000, "irq after abort");
      reg_read(dma_channel_control_pkg::CTRL_OFFSET, d);
      check(d & 32'h0000_0002, 32'h0000_0000, "end flag after abort");
      slow <= 1'b0;
      $display("test abort done");
   endtask : test_abort

   task test_gap_modes;
      logic [31:0] d;
      int          n;
      int          gap;
      int          lim;
      for (int m = 1; m < 4; m++) begin
         lim = 16 << (2 * (m - 1));
         reg_read(dma_channel_control_pkg::CTRL_OFFSET, d);
         reg_write(dma_channel_control_pkg::COUNT_OFFSET, 32'h0000_0002);
         reg_write(dma_channel_control_pkg::CTRL_OFFSET, 32'h0000_0001 | (m << 4));
         wait_bus(1'b1, n);
         wait_bus(1'b0, n);
         wait_bus(1'b1, gap);
         check(32'(gap >= lim && gap <= lim + 4), 32'h0000_0001, "release gap");
         wait_bus(1'b0, n);
      end
      $display("test gap_modes done");
   endtask : test_gap_modes

   // overrun 1 on a handshake source: acknowledge shown, one idle cycle per unit
   task test_overrun_handshake;
      logic [31:0] d;
      logic        acked;
      int          n;
      int          gap;
      acked = 1'b0;
      reg_read(dma_channel_control_pkg::CTRL_OFFSET, d);
      reg_write(dma_channel_control_pkg::COUNT_OFFSET, 32'h0000_0002);
      reg_write(dma_channel_control_pkg::CTRL_OFFSET, 32'h0080_2001);
      wait_bus(1'b1, n);
      repeat (4) @(negedge sys_clk) acked |= transfer_acknowledge_pin;
      check(32'(acked), 32'h0000_0001, "handshake acknowledge");
      wait_bus(1'b0, n);
      wait_bus(1'b1, gap);
      check(32'(gap), 32'h0000_0001, "overrun 1 idle cycle");
      wait_bus(1'b0, n);
      check(32'(transfer_acknowledge_pin), 32'h0000_0000, "acknowledge released");
      $display("test overrun_handshake done");
   endtask : test_overrun_handshake

   task end_of_test;
      $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test

   initial begin
      do_reset();
      test_full_transfer();
      test_end_flag_block();
      test_bad_pairing();
      do_reset();
      test_abort();
      test_gap_modes();
      test_overrun_handshake();
      end_of_test();
   end

   // the whole run needs about a thousand cycles; ten thousand is ample
   initial begin
      #40000;
      fail_count++;
      end_of_test();
   end
endmodule : dma_channel_control_bench

/* File: test/dma_far_side_model.sv */
`timescale 1ns/1ns
// arbiter and memory beside the channel; slow stretches the read and write done answers, not the grant
module dma_far_side_model (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic slow,
   input  wire logic bus_request,
   input  wire logic read_strobe,
   input  wire logic write_strobe,
   output logic      bus_grant = 1'b0,
   output logic      read_done = 1'b0,
   output logic      write_done = 1'b0
);
   logic [3:0] rd_wait_q = 4'h0;
   logic [3:0] wr_wait_q = 4'h0;

   // a done pulse only ever follows its own strobe, never unasked
   always @(posedge sys_clk) begin
      bus_grant <= bus_request & ~rst;
      read_done <= rd_wait_q == 4'h1;
      write_done <= wr_wait_q == 4'h1;
      if (rst)
         rd_wait_q <= 4'h0;
      else if (read_strobe)
         rd_wait_q <= slow ? 4'h6 : 4'h1;
      else if (rd_wait_q != 4'h0)
         rd_wait_q <= rd_wait_q - 4'h1;
      if (rst)
         wr_wait_q <= 4'h0;
      else if (write_strobe)
         wr_wait_q <= slow ? 4'h6 : 4'h1;
      else if (wr_wait_q != 4'h0)
         wr_wait_q <= wr_wait_q - 4'h1;
   end
endmodule : dma_far_side_model
